// >>> logic/lsp_top.sv
// Positioning logic by sensors or limit switches, with distance stop.
`timescale 1ns/1ps
module lsp_top import lsp_pkg::*; (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Register port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Sensor inputs: slow fw, slow rv, stop fw, stop rv.
	input wire logic [NCH-1:0] sensor_in,
	input wire logic disable_in,
	// Motor state.
	input wire logic run_fw,
	input wire logic run_rv,
	input wire logic [VAL_W-1:0] speed_est,
	// Retained latch state.
	input wire logic [NCH-1:0] nv_restore,
	output logic [NCH-1:0] nv_save,
	// Commands to the drive.
	output logic slow_fw_cmd,
	output logic slow_rv_cmd,
	output logic stop_cmd,
	output logic decel_cmd
);
	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic [BITS_W-1:0] bits_q;
	logic [BITS_W-1:0] bits_d;
	logic [VAL_W-1:0] dist_q;
	logic [VAL_W-1:0] dist_d;
	logic [VAL_W-1:0] rated_q;
	logic [VAL_W-1:0] rated_d;
	logic [VAL_W-1:0] ramp_q;
	logic [VAL_W-1:0] ramp_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [NCH-1:0] latch_q;
	logic [NCH-1:0] latch_d;
	logic restore_q;
	logic restore_d;
	logic trip_fw_q;
	logic trip_fw_d;
	logic [NCH-1:0] smp;
	logic [NCH-1:0] act_edge;
	logic [NCH-1:0] ina_edge;
	logic [NCH-1:0] act_lvl;
	logic dis;
	logic ramp_chg;
	logic dir_chg;
	logic trip;
	lsp_dist_if dif ();

	// Direction of a channel: even channels face forward.
	function automatic logic ch_fwd(input int ch);
		return (ch % 2) == 0;
	endfunction

	// Running in the channel's own direction or against it.
	function automatic logic ch_run(input int ch, input logic same, input logic fw,
		input logic rv);
		return (ch_fwd(ch) == same) ? fw : rv;
	endfunction

	// Sensors come from pins or from control-word bits.
	assign smp = ctrl_q[CTRL_SRC_BITS] ? bits_q[NCH-1:0] : sensor_in;
	assign dis = ctrl_q[CTRL_DIS] | bits_q[BITS_DIS] | disable_in;

	lsp_edge #(.W(NCH)) u_edge (
		.mclk(mclk),
		.srst(srst),
		.smp(smp),
		.pol_rise(ctrl_q[CTRL_POL]),
		.act_edge(act_edge),
		.ina_edge(ina_edge),
		.act_lvl(act_lvl)
	);

	// Register writes.
	always_comb begin
		ctrl_d = ctrl_q;
		bits_d = bits_q;
		dist_d = dist_q;
		rated_d = rated_q;
		ramp_d = ramp_q;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: ctrl_d = reg_wdata[CTRL_W-1:0];
				OFS_BITS: bits_d = reg_wdata[BITS_W-1:0];
				OFS_DIST: dist_d = reg_wdata[VAL_W-1:0];
				OFS_RATED: rated_d = reg_wdata[VAL_W-1:0];
				OFS_RAMP: ramp_d = reg_wdata[VAL_W-1:0];
				default: ;
			endcase
		end
	end

	// Register reads; unmapped offsets answer zero.
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL: rdata_d = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
				OFS_BITS: rdata_d = {{(DATA_W-BITS_W){1'b0}}, bits_q};
				OFS_DIST: rdata_d = {16'h0000, dist_q};
				OFS_RATED: rdata_d = {16'h0000, rated_q};
				OFS_RAMP: rdata_d = {16'h0000, ramp_q};
				OFS_STATUS: begin
					rdata_d[ST_LATCH +: NCH] = latch_q;
					rdata_d[ST_DIST_ACT] = dif.active;
					rdata_d[ST_DIST_DONE] = dif.done;
					rdata_d[ST_DECEL] = decel_cmd;
					rdata_d[ST_DIS] = dis;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	// Latches track sensors whether or not the function is disabled.
	always_comb begin
		latch_d = latch_q;
		restore_d = 1'b0;
		if (restore_q) begin
			latch_d = nv_restore; // RULE_02
		end else if (ctrl_q[CTRL_LONG_CAM]) begin
			// Long cams cover the zone, so the level itself gives the position.
			latch_d = act_lvl; // RULE_08
		end else begin
			for (int ch = 0; ch < NCH; ch++) begin
				if (act_edge[ch] && ch_run(ch, 1'b1, run_fw, run_rv)) begin
					latch_d[ch] = 1'b1; // RULE_01 RULE_16 RULE_06
				end else if (ina_edge[ch] && ch_run(ch, 1'b0, run_fw, run_rv)) begin
					latch_d[ch] = 1'b0; // RULE_04 RULE_16
				end
			end
		end
	end

	// Distance-stop control.
	assign trip = !restore_q && !ctrl_q[CTRL_LONG_CAM] && !dis && ctrl_q[CTRL_DIST_EN]
		&& ((act_edge[CH_SLOW_FW] && run_fw) || (act_edge[CH_SLOW_RV] && run_rv));
	assign ramp_chg = reg_wr && reg_addr == OFS_RAMP && reg_wdata[VAL_W-1:0] != ramp_q;
	assign dir_chg = trip_fw_q ? run_rv : run_fw;

	always_comb begin
		trip_fw_d = trip_fw_q;
		if (trip) begin
			trip_fw_d = run_fw;
		end
	end

	assign dif.start = trip; // RULE_09
	assign dif.abort = dif.active && (ramp_chg || dir_chg); // RULE_12 RULE_13
	assign dif.profile = ctrl_q[CTRL_PROFILE]; // RULE_11
	assign dif.distance = dist_q;
	assign dif.rated = rated_q;
	assign dif.speed = speed_est;

	lsp_dist u_dist (
		.mclk(mclk),
		.srst(srst),
		.dif(dif)
	);

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_q <= CTRL_RST;
			bits_q <= BITS_RST;
			dist_q <= DIST_RST;
			rated_q <= RATED_RST;
			ramp_q <= RAMP_RST;
			rdata_q <= '0;
			latch_q <= '0;
			restore_q <= 1'b1;
			trip_fw_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			bits_q <= bits_d;
			dist_q <= dist_d;
			rated_q <= rated_d;
			ramp_q <= ramp_d;
			rdata_q <= rdata_d;
			latch_q <= latch_d;
			restore_q <= restore_d;
			trip_fw_q <= trip_fw_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign nv_save = latch_q; // RULE_02
	// Slowdown acts only toward the latched end; the other way runs free.
	assign slow_fw_cmd = latch_q[CH_SLOW_FW] && run_fw && !dis; // RULE_03 RULE_05
	assign slow_rv_cmd = latch_q[CH_SLOW_RV] && run_rv && !dis; // RULE_05
	// The stop switch stops the motor whatever the distance engine is doing.
	assign stop_cmd = (latch_q[CH_STOP_FW] && run_fw) || (latch_q[CH_STOP_RV] && run_rv)
		|| dif.done; // RULE_10
	assign decel_cmd = dif.decel_req && !stop_cmd; // RULE_10

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	set_fw_a: assert property (act_edge[CH_SLOW_FW] && run_fw && !restore_q
		&& !ctrl_q[CTRL_LONG_CAM] |=> latch_q[CH_SLOW_FW]) // RULE_01
		else $error("forward slowdown not latched");
	no_set_a: assert property (act_edge[CH_SLOW_FW] && !run_fw && !latch_q[CH_SLOW_FW]
		&& !restore_q && !ctrl_q[CTRL_LONG_CAM] |=> !latch_q[CH_SLOW_FW]) // RULE_01
		else $error("forward slowdown latched outside forward run");
	clr_rv_a: assert property (ina_edge[CH_SLOW_FW] && run_rv && !act_edge[CH_SLOW_FW]
		&& !restore_q && !ctrl_q[CTRL_LONG_CAM] |=> !latch_q[CH_SLOW_FW]) // RULE_04
		else $error("forward slowdown not cleared in reverse");
	restore_a: assert property ($fell(restore_q) |-> latch_q == $past(nv_restore)) // RULE_02
		else $error("latch not restored after reset");
	rev_free_a: assert property (run_rv && !run_fw |-> !slow_fw_cmd) // RULE_03
		else $error("reverse run held by forward slowdown");
	dis_gate_a: assert property (dis |-> !slow_fw_cmd && !slow_rv_cmd) // RULE_05
		else $error("slowdown active while disabled");
	dis_track_a: assert property (dis && act_edge[CH_STOP_FW] && run_fw && !restore_q
		&& !ctrl_q[CTRL_LONG_CAM] |=> latch_q[CH_STOP_FW]) // RULE_06
		else $error("sensor not tracked while disabled");
	long_cam_a: assert property (ctrl_q[CTRL_LONG_CAM] && !restore_q
		|=> latch_q == $past(act_lvl)) // RULE_08
		else $error("long cam latch not following level");
	stop_wins_a: assert property (latch_q[CH_STOP_FW] && run_fw |-> stop_cmd && !decel_cmd)
		else $error("stop switch overridden"); // RULE_10
	dir_abort_a: assert property (dif.active && dir_chg |=> !dif.active && !dif.done)
		else $error("distance stop kept after reversal"); // RULE_13

	// Slowdown and stop share one latch logic; these check the other channels.
	set_rv_a: assert property (act_edge[CH_SLOW_RV] && run_rv && !restore_q // RULE_16
		&& !ctrl_q[CTRL_LONG_CAM] |=> latch_q[CH_SLOW_RV])
		else $error("reverse slowdown not latched");
	set_stop_a: assert property (act_edge[CH_STOP_RV] && run_rv && !restore_q // RULE_16
		&& !ctrl_q[CTRL_LONG_CAM] |=> latch_q[CH_STOP_RV])
		else $error("reverse stop not latched");
	clr_stop_a: assert property (ina_edge[CH_STOP_FW] && run_rv // RULE_16
		&& !act_edge[CH_STOP_FW] && !restore_q && !ctrl_q[CTRL_LONG_CAM] |=> !latch_q[CH_STOP_FW])
		else $error("forward stop not cleared in reverse");
	fw_free_a: assert property (run_fw && !run_rv |-> !slow_rv_cmd) // RULE_16
		else $error("forward run held by reverse slowdown");
	// Without an edge the latch must not move, so one transition is one event.
	latch_hold_a: assert property (!restore_q && !ctrl_q[CTRL_LONG_CAM] // RULE_17
		&& act_edge == '0 && ina_edge == '0 |=> latch_q == $past(latch_q))
		else $error("latch moved without an edge");
	// A falling sample must give an active edge when the falling polarity is chosen.
	pol_fall_a: assert property (!ctrl_q[CTRL_POL] && $fell(smp[0]) && !$past(srst) // RULE_15
		|-> act_edge[0])
		else $error("falling edge not taken as active");

	// A disabled function may neither raise slow_fw_cmd or slow_rv_cmd nor start a distance stop; one already running keeps its decel_cmd.
	dis_trip_a: assert property (dis |-> !dif.start) // RULE_05
		else $error("distance stop started while disabled");
	trip_run_a: assert property (dif.start |=> dif.active) // RULE_09
		else $error("trip did not start the distance stop");
	done_stop_a: assert property (dif.done |-> stop_cmd) // RULE_09
		else $error("distance reached without stop command");
	stop_decel_a: assert property (stop_cmd |-> !decel_cmd) // RULE_10
		else $error("decelerate request beside a stop");
	prof0_decel_a: assert property (dif.active && !dif.profile // RULE_11
		|-> decel_cmd || stop_cmd)
		else $error("immediate profile did not decelerate");
	ramp_abort_a: assert property (dif.active && ramp_chg // RULE_12
		|=> !dif.active && !dif.done)
		else $error("distance stop kept after ramp change");
	no_resume_a: assert property ($past(srst) |-> !dif.active && !dif.done) // RULE_14
		else $error("distance stop resumed after reset");

	// Register port: a write lands next cycle, read data stand one cycle only.
	ctrl_wr_a: assert property (reg_wr && reg_addr == OFS_CTRL
		|=> ctrl_q == $past(reg_wdata[CTRL_W-1:0]))
		else $error("control write lost");
	bits_wr_a: assert property (reg_wr && reg_addr == OFS_BITS
		|=> bits_q == $past(reg_wdata[BITS_W-1:0]))
		else $error("control-word bits write lost");
	dist_wr_a: assert property (reg_wr && reg_addr == OFS_DIST
		|=> dist_q == $past(reg_wdata[VAL_W-1:0]))
		else $error("distance write lost");
	rated_wr_a: assert property (reg_wr && reg_addr == OFS_RATED
		|=> rated_q == $past(reg_wdata[VAL_W-1:0]))
		else $error("rated speed write lost");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside the read answer");

	trip_c: cover property (trip ##[1:50] dif.done);
	abort_c: cover property (dif.active && ramp_chg);
	clear_c: cover property (latch_q[CH_SLOW_FW] ##1 !latch_q[CH_SLOW_FW]);
	dis_c: cover property (dis && act_edge[CH_SLOW_FW] && run_fw);
	long_c: cover property (ctrl_q[CTRL_LONG_CAM] && latch_q != $past(latch_q));
endmodule

// >>> logic/lsp_pkg.sv
// Constants and register map for the limit-switch positioning block.
// Behaviour
// RULE_01: Forward slowdown latches on active edge of its input while running forward.
// RULE_02: Slowdown latch state is saved outside and restored after power-up.
// RULE_03: With forward slowdown latched, reverse running stays at full speed.
// RULE_04: Forward slowdown latch clears on inactive edge while running reverse.
// RULE_05: A disable input or control bit suppresses the slowdown action while high.
// RULE_06: While disabled, sensor edges are still tracked and the latch updated.
// RULE_07: With short cams, operator first starts outside slowdown and stop zones.
// RULE_08: With long cams, the latch initialises from any position along the travel.
// RULE_09: Distance stop halts the load after a preset distance from the slowdown trip.
// RULE_10: The stop limit switch always overrides the distance stop.
// RULE_11: A deceleration-type setting selects between two distance-stop behaviours.
// RULE_12: Changing the ramp setting during a distance stop abandons the distance.
// RULE_13: Reversing direction during a distance stop abandons the distance.
// RULE_14: A distance stop in progress is not resumed after power-up.
// RULE_15: Sensor inputs act on rising or on falling edge, as configured.
// RULE_16: Identical latch logic serves both directions and both slowdown and stop.
// RULE_17: Inputs are sampled every cycle; one transition gives exactly one event.
package lsp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NCH = 4;
	// Channel indices: slowdown and stop, forward and reverse.
	localparam int CH_SLOW_FW = 0;
	localparam int CH_SLOW_RV = 1;
	localparam int CH_STOP_FW = 2;
	localparam int CH_STOP_RV = 3;
	// Register offsets.
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_BITS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DIST = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RATED = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_RAMP = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	// Control register fields.
	localparam int CTRL_POL = 0;
	localparam int CTRL_DIS = 1;
	localparam int CTRL_DIST_EN = 2;
	localparam int CTRL_PROFILE = 3;
	localparam int CTRL_SRC_BITS = 4;
	localparam int CTRL_LONG_CAM = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
	// Control-word bit register: four sensor bits then the disable bit.
	localparam int BITS_DIS = 4;
	localparam int BITS_W = 5;
	localparam logic [BITS_W-1:0] BITS_RST = 5'h00;
	localparam int VAL_W = 16;
	localparam logic [VAL_W-1:0] DIST_RST = 16'h0000;
	localparam logic [VAL_W-1:0] RATED_RST = 16'h0001;
	localparam logic [VAL_W-1:0] RAMP_RST = 16'h0000;
	// Status register fields.
	localparam int ST_LATCH = 0;
	localparam int ST_DIST_ACT = 4;
	localparam int ST_DIST_DONE = 5;
	localparam int ST_DECEL = 6;
	localparam int ST_DIS = 7;
	// Cycles of deceleration assumed per unit of trip speed for the late-decel profile.
	localparam int DECEL_CYC = 16;
	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_RUN = 2'b01,
		DS_DONE = 2'b10
	} lsp_dstate_type;
endpackage

// >>> logic/lsp_dist_if.sv
// Interface between the positioning core and its distance-stop engine.
`timescale 1ns/1ps
interface lsp_dist_if;
	logic start;
	logic abort;
	logic profile;
	logic [15:0] distance;
	logic [15:0] rated;
	logic [15:0] speed;
	logic active;
	logic decel_req;
	logic done;
	modport core (output start, abort, profile, distance, rated, speed,
		input active, decel_req, done);
	modport eng (input start, abort, profile, distance, rated, speed,
		output active, decel_req, done);
endinterface

// >>> logic/lsp_edge.sv
// Per-channel edge detector with selectable active edge.
`timescale 1ns/1ps
module lsp_edge import lsp_pkg::*; #(
	parameter int W = 4
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Samples and polarity.
	input wire logic [W-1:0] smp,
	input wire logic pol_rise,
	// Events and levels.
	output logic [W-1:0] act_edge,
	output logic [W-1:0] ina_edge,
	output logic [W-1:0] act_lvl
);
	logic [W-1:0] prev_q;
	logic [W-1:0] prev_d;
	logic [W-1:0] rise;
	logic [W-1:0] fall;

	always_comb begin
		prev_d = smp;
		rise = smp & ~prev_q; // RULE_17
		fall = ~smp & prev_q;
		act_edge = pol_rise ? rise : fall; // RULE_15
		ina_edge = pol_rise ? fall : rise;
		act_lvl = pol_rise ? smp : ~smp;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	one_event_a: assert property (@(posedge mclk) disable iff (srst)
		!(act_edge[0] && $past(act_edge[0]) && !$past(srst))) // RULE_17
		else $error("edge event lasted two cycles");
endmodule

// >>> logic/lsp_dist.sv
// Distance-stop engine: travels a preset distance after the slowdown trip.
`timescale 1ns/1ps
module lsp_dist import lsp_pkg::*; (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Link to the core.
	lsp_dist_if.eng dif
);
	lsp_dstate_type st_q;
	lsp_dstate_type st_d;
	logic [31:0] acc_q;
	logic [31:0] acc_d;
	logic [31:0] tgt_q;
	logic [31:0] tgt_d;
	logic [31:0] ramp_q;
	logic [31:0] ramp_d;
	logic late;

	always_comb begin
		st_d = st_q;
		acc_d = acc_q;
		tgt_d = tgt_q;
		ramp_d = ramp_q;
		late = 1'b0;
		case (st_q)
			DS_IDLE, DS_DONE: begin
				if (dif.start) begin
					// Stop point from distance and rated speed; ramp from the speed at the trip.
					st_d = DS_RUN; // RULE_09
					acc_d = '0;
					tgt_d = dif.distance * dif.rated;
					ramp_d = dif.speed * 32'(DECEL_CYC);
				end
			end
			DS_RUN: begin
				acc_d = acc_q + {16'h0000, dif.speed};
				late = (acc_q + ramp_q) >= tgt_q;
				if (acc_q >= tgt_q) begin
					st_d = DS_DONE;
				end
			end
			default: st_d = DS_IDLE;
		endcase
		if (dif.abort) begin
			st_d = DS_IDLE; // RULE_12 RULE_13
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= DS_IDLE; // RULE_14
			acc_q <= '0;
			tgt_q <= '0;
			ramp_q <= '0;
		end else begin
			st_q <= st_d;
			acc_q <= acc_d;
			tgt_q <= tgt_d;
			ramp_q <= ramp_d;
		end
	end

	assign dif.active = (st_q == DS_RUN);
	assign dif.done = (st_q == DS_DONE);
	// Profile 0 decelerates at once; profile 1 holds speed until the ramp fits.
	assign dif.decel_req = (st_q == DS_RUN) && (!dif.profile || late); // RULE_11

	abort_idle_a: assert property (@(posedge mclk) disable iff (srst)
		dif.abort |=> st_q == DS_IDLE) // RULE_13
		else $error("distance stop survived an abort");
	reach_done_a: assert property (@(posedge mclk) disable iff (srst)
		(st_q == DS_RUN && acc_q >= tgt_q && !dif.abort) |=> dif.done) // RULE_09
		else $error("distance reached without stop");
endmodule

// >>> dv/lsp_sensor_model.sv
// Model of the cams and limit switches that the moving part trips along its travel.
`timescale 1ns/1ps
module lsp_sensor_model import lsp_pkg::*; #(
	parameter int SLOW_FW_AT = 200,
	parameter int STOP_FW_AT = 240,
	parameter int SLOW_RV_AT = 50,
	parameter int STOP_RV_AT = 10
) (
	// Clock.
	input wire logic mclk,
	// Position of the moving part.
	input wire logic [7:0] pos,
	// Switch levels: slow fw, slow rv, stop fw, stop rv.
	output logic [NCH-1:0] sensor
);
	// Long cams: each switch stays closed over its whole zone, so the level tells the position.
	// The bench starts the travel outside every zone so short cams initialise too.
	initial sensor = 4'h0;
	always @(posedge mclk) begin
		sensor[CH_SLOW_FW] <= (int'(pos) >= SLOW_FW_AT);
		sensor[CH_STOP_FW] <= (int'(pos) >= STOP_FW_AT);
		sensor[CH_SLOW_RV] <= (int'(pos) <= SLOW_RV_AT);
		sensor[CH_STOP_RV] <= (int'(pos) <= STOP_RV_AT);
	end
endmodule

// >>> dv/tb_limit_switch_positioning.sv
// Self-checking bench for the limit-switch positioning block.
`timescale 1ns/1ps
module tb_limit_switch_positioning import lsp_pkg::*;;
	typedef struct {
		logic fw;
		logic rv;
		logic dis;
		logic [7:0] pos;
		logic [3:0] nv;
		logic sf;
		logic sr;
		logic st;
	} lsp_row_type;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [NCH-1:0] sensor_in;
	logic disable_in = 1'b0;
	logic run_fw = 1'b0;
	logic run_rv = 1'b0;
	logic [VAL_W-1:0] speed_est = 16'h0001;
	logic [NCH-1:0] nv_restore = 4'h0;
	logic [NCH-1:0] nv_save;
	logic slow_fw_cmd;
	logic slow_rv_cmd;
	logic stop_cmd;
	logic decel_cmd;
	logic [7:0] pos = 8'h64;
	int err_count = 0;
	int comparisons = 0;
	// Each row: direction, disable, position, then latch image and commands expected.
	lsp_row_type rows[13] = '{
		'{1'b1, 1'b0, 1'b0, 8'h64, 4'h0, 1'b0, 1'b0, 1'b0},
		'{1'b1, 1'b0, 1'b0, 8'hd2, 4'h1, 1'b1, 1'b0, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'hd2, 4'h1, 1'b0, 1'b0, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'h96, 4'h0, 1'b0, 1'b0, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'hd2, 4'h0, 1'b0, 1'b0, 1'b0},
		'{1'b1, 1'b0, 1'b0, 8'h96, 4'h0, 1'b0, 1'b0, 1'b0},
		'{1'b1, 1'b0, 1'b1, 8'hd2, 4'h1, 1'b0, 1'b0, 1'b0},
		'{1'b1, 1'b0, 1'b0, 8'hd2, 4'h1, 1'b1, 1'b0, 1'b0},
		'{1'b1, 1'b0, 1'b0, 8'hf5, 4'h5, 1'b1, 1'b0, 1'b1},
		'{1'b0, 1'b1, 1'b0, 8'h96, 4'h0, 1'b0, 1'b0, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'h28, 4'h2, 1'b0, 1'b1, 1'b0},
		'{1'b0, 1'b1, 1'b0, 8'h05, 4'ha, 1'b0, 1'b1, 1'b1},
		'{1'b1, 1'b0, 1'b0, 8'h64, 4'h0, 1'b0, 1'b0, 1'b0}
	};

	initial begin
		forever #5 mclk = ~mclk;
	end

	lsp_sensor_model u_sensors (.mclk(mclk), .pos(pos), .sensor(sensor_in));

	lsp_top u_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sensor_in(sensor_in),
		.disable_in(disable_in), .run_fw(run_fw), .run_rv(run_rv), .speed_est(speed_est),
		.nv_restore(nv_restore), .nv_save(nv_save), .slow_fw_cmd(slow_fw_cmd),
		.slow_rv_cmd(slow_rv_cmd), .stop_cmd(stop_cmd), .decel_cmd(decel_cmd));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", exp, reg_rdata);
	endtask

	// Moves the part and waits for the switch model and the latch to follow.
	task automatic step(input logic fw, input logic rv, input logic dis, input logic [7:0] p);
		@(posedge mclk);
		run_fw <= fw;
		run_rv <= rv;
		disable_in <= dis;
		pos <= p;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task automatic rst(input logic [3:0] nv);
		@(posedge mclk);
		srst <= 1'b1;
		nv_restore <= nv;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#200us;
		err_count++;
		wrap_up();
	end

	initial begin
		int i;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		foreach (rows[r]) begin
			step(rows[r].fw, rows[r].rv, rows[r].dis, rows[r].pos);
			chk("nv_save", {28'h0, rows[r].nv}, {28'h0, nv_save});
			chk("slow_fw_cmd", {31'h0, rows[r].sf}, {31'h0, slow_fw_cmd});
			chk("slow_rv_cmd", {31'h0, rows[r].sr}, {31'h0, slow_rv_cmd});
			chk("stop_cmd", {31'h0, rows[r].st}, {31'h0, stop_cmd});
		end
		// Falling-edge polarity: the release of the switch is now the active edge.
		wr(OFS_CTRL, 32'h0);
		step(1'b1, 1'b0, 1'b0, 8'hd2);
		chk("nv_save", 32'h0, {28'h0, nv_save});
		step(1'b1, 1'b0, 1'b0, 8'h96);
		chk("nv_save", 32'h1, {28'h0, nv_save});
		rst(4'h0);
		chk("nv_save", 32'h0, {28'h0, nv_save});
		rd(OFS_CTRL, {26'h0, CTRL_RST});
		rd(OFS_RATED, {16'h0, RATED_RST});
		rd(OFS_DIST, {16'h0, DIST_RST});
		rd(8'h18, 32'h0);
		wr(OFS_STATUS, 32'hff);
		rd(OFS_STATUS, 32'h0);
		// Sensor and disable taken from the control-word bits instead of the pins.
		step(1'b1, 1'b0, 1'b0, 8'h64);
		wr(OFS_CTRL, 32'h11);
		wr(OFS_BITS, 32'h11);
		repeat (2) @(posedge mclk);
		#1;
		chk("slow_fw_cmd", 32'h0, {31'h0, slow_fw_cmd});
		chk("nv_save", 32'h1, {28'h0, nv_save});
		wr(OFS_BITS, 32'h01);
		repeat (2) @(posedge mclk);
		#1;
		chk("slow_fw_cmd", 32'h1, {31'h0, slow_fw_cmd});
		rst(4'h0);
		// Distance stop under both deceleration profiles.
		for (int p = 0; p < 2; p++) begin
			wr(OFS_CTRL, 32'h05 | (p << CTRL_PROFILE));
			wr(OFS_DIST, 32'd40);
			step(1'b1, 1'b0, 1'b0, 8'h96);
			step(1'b1, 1'b0, 1'b0, 8'hd2);
			chk("decel_cmd", (p == 0) ? 32'h1 : 32'h0, {31'h0, decel_cmd});
			chk("stop_cmd", 32'h0, {31'h0, stop_cmd});
			rd(OFS_STATUS, (p == 0) ? 32'h51 : 32'h11);
			for (i = 0; i < 60 && stop_cmd !== 1'b1; i++) @(posedge mclk);
			#1;
			chk("stop_cmd", 32'h1, {31'h0, stop_cmd});
		end
		wr(OFS_CTRL, 32'h05);
		wr(OFS_DIST, 32'd200);
		step(1'b1, 1'b0, 1'b0, 8'h96);
		step(1'b1, 1'b0, 1'b0, 8'hd2);
		chk("stop_cmd", 32'h0, {31'h0, stop_cmd});
		step(1'b1, 1'b0, 1'b0, 8'hf5);
		chk("stop_cmd", 32'h1, {31'h0, stop_cmd});
		step(1'b0, 1'b1, 1'b0, 8'h96);
		step(1'b1, 1'b0, 1'b0, 8'hd2);
		step(1'b0, 1'b1, 1'b0, 8'hd2);
		repeat (250) @(posedge mclk);
		#1;
		chk("stop_cmd", 32'h0, {31'h0, stop_cmd});
		step(1'b1, 1'b0, 1'b0, 8'h96);
		step(1'b1, 1'b0, 1'b0, 8'hd2);
		wr(OFS_RAMP, 32'h5);
		repeat (250) @(posedge mclk);
		#1;
		chk("stop_cmd", 32'h0, {31'h0, stop_cmd});
		step(1'b1, 1'b0, 1'b0, 8'h96);
		step(1'b1, 1'b0, 1'b0, 8'hd2);
		step(1'b0, 1'b0, 1'b0, 8'hd2);
		rst(4'h5);
		chk("nv_save", 32'h5, {28'h0, nv_save});
		repeat (250) @(posedge mclk);
		#1;
		chk("stop_cmd", 32'h0, {31'h0, stop_cmd});
		chk("decel_cmd", 32'h0, {31'h0, decel_cmd});
		// Long cams: the latch follows the switch levels from wherever the part stands.
		wr(OFS_CTRL, 32'h21);
		repeat (2) @(posedge mclk);
		#1;
		chk("nv_save", 32'h1, {28'h0, nv_save});
		step(1'b0, 1'b1, 1'b0, 8'h05);
		chk("nv_save", 32'ha, {28'h0, nv_save});
		chk("slow_rv_cmd", 32'h1, {31'h0, slow_rv_cmd});
		chk("stop_cmd", 32'h1, {31'h0, stop_cmd});
		wrap_up();
	end
endmodule
